// ===== hw/bbc_buffer_ctrl.sv
`timescale 1ns/1ps
module bbc_buffer_ctrl
  import bbc_pkg::*;
(
  input  wire logic i_clk,                    // 200 MHz core clock
  input  wire logic i_arst_n,                 // async reset, low
  input  wire logic i_bus_clk,                // backplane clock pin
  input  wire logic i_start_n,                // bus start, low
  input  wire logic i_ack_n,                  // bus ack wire level
  input  wire logic i_tm0_n,                  // bus tm0, interim ack
  input  wire logic i_slave_access_grant_n,   // slave grant, low
  input  wire logic i_slave_interim_ack_n,    // block middle strobe
  input  wire logic i_local_ack_request_n,    // local board ready
  input  wire logic i_master_data_hold_n,     // keep read data
  input  wire logic i_card_id_match_n,        // card addressed, low
  input  wire logic i_master_go_n,            // master start request
  input  wire logic i_cycle_write,            // current cycle write
  input  wire logic i_cycle_block,            // current cycle block
  output logic      o_bus_drive_enable_n,     // bus transceiver oe
  output logic      o_local_addr_enable_n,    // local address oe
  output logic      o_local_data_enable_n,    // local data oe
  output logic      o_local_data_load_strobe, // local data load
  output logic      o_addr_load_strobe,       // local address load
  output logic      o_addr_sel_n,             // low address, high data
  output logic      o_ack_out,                // ack level when driven
  output logic      o_ack_oe,                 // ack driver enable
  output logic      o_slave_selected          // card is the slave
);

  logic              rst_q1_reg;   // reset release stage one
  logic              rst_n;        // synchronised reset
  logic [SYNC_W-1:0] pin_raw;      // pins gathered
  logic [SYNC_W-1:0] s1_reg;       // first stage, feeds s2 only
  logic [SYNC_W-1:0] s2_reg;       // second stage
  logic [SYNC_W-1:0] s3_reg;       // third stage
  logic [SYNC_W-1:0] pin_reg;      // agreed, filtered levels
  logic              bclk_d_reg;   // previous backplane clock
  logic              bclk_rise;    // driving edge pulse
  logic              bclk_fall;    // sample edge pulse
  bbc_mst_t          m_state_reg;  // master sequencer
  bbc_slv_t          s_state_reg;  // slave sequencer
  logic              m_write_reg;  // master cycle is write
  logic              m_block_reg;  // master cycle is block
  logic              s_write_reg;  // slave cycle is write
  logic              s_block_reg;  // slave cycle is block
  logic              s_local_ack_request_n_reg;   // local ack seen at sample edge
  logic [1:0]        stb_cnt_reg;  // strobe high cycles left
  logic              start_s;      // start seen (low) and no ack
  logic              grant_on;     // slave grant asserted
  logic              sel_now;      // selected at this sample edge

  assign pin_raw = {i_cycle_block, i_cycle_write, i_master_go_n,
                    i_card_id_match_n, i_master_data_hold_n,
                    i_local_ack_request_n, i_slave_interim_ack_n,
                    i_slave_access_grant_n, i_tm0_n, i_ack_n,
                    i_start_n, i_bus_clk};

  // reset released through two flops, asserted at once
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n      <= rst_q1_reg;
    end
  end

  // three-flop synchroniser per pin; a change counts once
  // stages two and three agree, which filters one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg[gi]  <= SYNC_RST[gi];
          s2_reg[gi]  <= SYNC_RST[gi];
          s3_reg[gi]  <= SYNC_RST[gi];
          pin_reg[gi] <= SYNC_RST[gi];
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            pin_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // backplane clock edges as one-cycle pulses
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d_reg <= 1'b0;
    end else begin
      bclk_d_reg <= pin_reg[IX_BCLK];
    end
  end

  assign bclk_rise = pin_reg[IX_BCLK] & ~bclk_d_reg;
  assign bclk_fall = ~pin_reg[IX_BCLK] & bclk_d_reg;
  assign start_s   = ~pin_reg[IX_START] & pin_reg[IX_ACK];
  assign grant_on  = ~pin_reg[IX_GRANT];
  // selected now: in S_SEL state, or identity matching this edge
  assign sel_now   = (s_state_reg == S_SEL) |
                     ((s_state_reg == S_ID) & ~pin_reg[IX_CARD_ID_MATCH_N]);

  // master sequencer: start on rise, ack taken on fall
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state_reg <= M_IDLE;
      m_write_reg <= 1'b0;
      m_block_reg <= 1'b0;
    end else begin
      case (m_state_reg)
        M_IDLE: begin
          if (bclk_rise && !pin_reg[IX_GO]) begin
            m_state_reg <= M_ADDR;
            m_write_reg <= pin_reg[IX_WRITE];
            m_block_reg <= pin_reg[IX_BLOCK];
          end
        end
        M_ADDR: begin
          if (bclk_rise) begin
            m_state_reg <= M_DATA;
          end
        end
        M_DATA: begin
          if (bclk_fall && !pin_reg[IX_ACK]) begin
            m_state_reg <= M_HOLD;
          end
        end
        default: begin
          // write ends at the next rise, read once hold released
          if (m_write_reg ? bclk_rise
                          : (bclk_fall && pin_reg[IX_HOLD])) begin
            m_state_reg <= M_IDLE;
          end
        end
      endcase
    end
  end

  // slave sequencer: start and identity on falls, ack on rises
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_state_reg <= S_IDLE;
      s_write_reg <= 1'b0;
      s_block_reg <= 1'b0;
      s_local_ack_request_n_reg  <= 1'b0;
    end else begin
      case (s_state_reg)
        S_IDLE: begin
          s_local_ack_request_n_reg <= 1'b0;
          if (bclk_fall && start_s) begin
            s_state_reg <= S_ID;
            s_write_reg <= pin_reg[IX_WRITE];
            s_block_reg <= pin_reg[IX_BLOCK];
          end
        end
        S_ID: begin
          if (bclk_fall) begin
            // identity looked at in the cycle after start
            s_state_reg <= pin_reg[IX_CARD_ID_MATCH_N] ? S_IDLE
                                            : S_SEL;
          end
        end
        S_SEL: begin
          if (bclk_fall && !pin_reg[IX_LOCAL_ACK_REQUEST_N]) begin
            s_local_ack_request_n_reg <= 1'b1;
          end
          if (bclk_rise && s_local_ack_request_n_reg) begin
            s_state_reg <= S_ACK;
          end
        end
        default: begin
          if (bclk_rise) begin
            s_state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // bus drive enable and address select change on rises
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_drive_enable_n <= RST_EN_N;
      o_addr_sel_n         <= RST_EN_N;
    end else if (bclk_rise) begin
      // address phase lasts exactly one bus period
      o_addr_sel_n <= ~((m_state_reg == M_IDLE) &
                        ~pin_reg[IX_GO]);
      if (m_state_reg == M_IDLE && !pin_reg[IX_GO]) begin
        o_bus_drive_enable_n <= 1'b0;
      end else if (m_state_reg == M_ADDR) begin
        // write keeps driving data, read lets go
        o_bus_drive_enable_n <= ~m_write_reg;
      end else if (m_state_reg == M_HOLD && m_write_reg) begin
        o_bus_drive_enable_n <= 1'b1;
      end else if (s_state_reg == S_SEL && s_local_ack_request_n_reg) begin
        o_bus_drive_enable_n <= s_write_reg;
      end else if (s_state_reg == S_ACK) begin
        o_bus_drive_enable_n <= 1'b1;
      end
    end
  end

  // ack driver: on the rise after the fall where local ack was seen
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ack_oe  <= 1'b0;
      o_ack_out <= 1'b0;
    end else if (bclk_rise) begin
      o_ack_oe <= (s_state_reg == S_SEL) & s_local_ack_request_n_reg;
    end
  end

  // selected flag for the slave side of the board
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_slave_selected <= 1'b0;
    end else begin
      o_slave_selected <= (s_state_reg == S_SEL) |
                          (s_state_reg == S_ACK);
    end
  end

  // local address enable and address load strobe on falls
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_local_addr_enable_n <= RST_EN_N;
      o_addr_load_strobe    <= RST_STB;
    end else if (bclk_fall) begin
      o_addr_load_strobe <= start_s;
      if (!grant_on) begin
        o_local_addr_enable_n <= 1'b1;
      end else if (sel_now) begin
        // covers grant already low on the edge after start
        o_local_addr_enable_n <= 1'b0;
      end
    end
  end

  // local data enable: master read tail or slave write grant
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_local_data_enable_n <= RST_EN_N;
    end else if (bclk_fall) begin
      if (m_state_reg == M_DATA && !m_write_reg &&
          !pin_reg[IX_ACK]) begin
        o_local_data_enable_n <= 1'b0;
      end else if (m_state_reg == M_HOLD && !m_write_reg) begin
        if (pin_reg[IX_HOLD]) begin
          o_local_data_enable_n <= 1'b1;
        end
      end else if (!grant_on) begin
        o_local_data_enable_n <= 1'b1;
      end else if (sel_now && s_write_reg) begin
        o_local_data_enable_n <= 1'b0;
      end
    end
  end

  // data load strobe; a running count keeps block strobes high
  // regardless of inputs, which is why it is checked first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_local_data_load_strobe <= RST_STB;
      stb_cnt_reg              <= 2'h0;
    end else if (bclk_fall) begin
      if (stb_cnt_reg != 2'h0) begin
        stb_cnt_reg <= stb_cnt_reg - STB_ONE_CYC;
        o_local_data_load_strobe <= (stb_cnt_reg != STB_ONE_CYC);
      end else if (m_state_reg == M_DATA && !m_write_reg) begin
        // pulse per ack, or per interim ack in block reads
        o_local_data_load_strobe <= ~pin_reg[IX_ACK] |
          (m_block_reg & ~pin_reg[IX_TM0]);
      end else if (sel_now && s_write_reg && s_block_reg) begin
        if (grant_on && o_local_addr_enable_n) begin
          o_local_data_load_strobe <= 1'b1;
          stb_cnt_reg <= BLK_FIRST_CYC;
        end else if (!pin_reg[IX_LOCAL_ACK_REQUEST_N]) begin
          o_local_data_load_strobe <= 1'b1;
          stb_cnt_reg <= STB_ONE_CYC;
        end else if (!pin_reg[IX_SLAVE_INTERIM_ACK_N]) begin
          o_local_data_load_strobe <= 1'b1;
          stb_cnt_reg <= STB_ONE_CYC;
        end else begin
          o_local_data_load_strobe <= 1'b0;
        end
      end else if (sel_now && s_write_reg) begin
        o_local_data_load_strobe <= grant_on;
      end else begin
        o_local_data_load_strobe <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  AST_MWR_DRIVE: assert property (
    (m_state_reg == M_DATA && m_write_reg) |-> !o_bus_drive_enable_n)
    else $error("master write lost bus drive before ack");
  AST_MRD_RELEASE: assert property (
    (m_state_reg == M_DATA && !m_write_reg) |-> o_bus_drive_enable_n)
    else $error("master read drives bus after start period");
  AST_SRD_ACK: assert property (
    (s_state_reg == S_ACK && !s_write_reg) |-> !o_bus_drive_enable_n)
    else $error("slave read ack cycle without bus drive");
  AST_AEN_ON: assert property (
    (bclk_fall && grant_on && sel_now) |=> !o_local_addr_enable_n)
    else $error("address enable not asserted after grant");
  AST_AEN_OFF: assert property (
    (bclk_fall && !grant_on) |=> o_local_addr_enable_n)
    else $error("address enable kept after grant released");
  AST_ID_SAMPLE: assert property (
    (bclk_fall && s_state_reg == S_ID && !pin_reg[IX_CARD_ID_MATCH_N])
    |=> s_state_reg == S_SEL ##1 o_slave_selected)
    else $error("identity match not taken after start");
  AST_ASEL_FALL: assert property (
    $fell(o_addr_sel_n) |-> $past(bclk_rise) && !o_bus_drive_enable_n)
    else $error("address select fell off the driving edge");
  AST_ASEL_ONE: assert property (
    (bclk_rise && !o_addr_sel_n && m_state_reg == M_ADDR)
    |=> o_addr_sel_n)
    else $error("address select held past one bus period");
  AST_ACK_DRIVE: assert property (
    (bclk_rise && s_state_reg == S_SEL && s_local_ack_request_n_reg)
    |=> o_ack_oe && s_state_reg == S_ACK)
    else $error("ack not driven after local ack");
  AST_MDEN_HOLD: assert property (
    (bclk_fall && m_state_reg == M_HOLD && !m_write_reg &&
     !pin_reg[IX_HOLD]) |=> !o_local_data_enable_n)
    else $error("read data enable dropped while hold asserted");
  AST_BLK_FIRST: assert property (
    (bclk_fall && stb_cnt_reg == 2'h0 &&
     $past(stb_cnt_reg) == 2'h0) ##1 (stb_cnt_reg == BLK_FIRST_CYC)
    |-> o_local_data_load_strobe)
    else $error("first block strobe not raised");

  COV_MASTER_WRITE: cover property (
    m_state_reg == M_HOLD && m_write_reg ##1 m_state_reg == M_IDLE);
  COV_MASTER_READ_HOLD: cover property (
    m_state_reg == M_HOLD && !m_write_reg && !o_local_data_enable_n);
  COV_SLAVE_ACK: cover property (o_ack_oe && o_slave_selected);
  COV_BLOCK_STROBE: cover property (
    stb_cnt_reg == BLK_FIRST_CYC && o_local_data_load_strobe);

endmodule // bbc_buffer_ctrl

// ===== hw/bbc_pkg.sv
package bbc_pkg;
  // index of each pin in the synchroniser vector
  localparam int IX_BCLK  = 0;   // backplane clock
  localparam int IX_START = 1;   // bus start, active low
  localparam int IX_ACK   = 2;   // bus acknowledge, active low
  localparam int IX_TM0   = 3;   // bus transfer mode 0, active low
  localparam int IX_GRANT = 4;   // slave access grant, active low
  localparam int IX_SLAVE_INTERIM_ACK_N = 5;   // slave interim ack, active low
  localparam int IX_LOCAL_ACK_REQUEST_N  = 6;   // local ack request, active low
  localparam int IX_HOLD  = 7;   // master data hold, active low
  localparam int IX_CARD_ID_MATCH_N  = 8;   // card identity match, active low
  localparam int IX_GO    = 9;   // local master start request, low
  localparam int IX_WRITE = 10;  // cycle is a write, high
  localparam int IX_BLOCK = 11;  // cycle is a block transfer, high
  localparam int SYNC_W   = 12;  // number of synchronised pins

  // synchroniser reset: strobes idle high, sense bits low
  localparam logic [SYNC_W-1:0] SYNC_RST = 12'h3FE;

  // output reset values
  localparam logic RST_EN_N = 1'b1;  // active-low enables inactive
  localparam logic RST_STB  = 1'b0;  // load strobes low

  // first block-write strobe spans two bus clocks
  localparam logic [1:0] BLK_FIRST_CYC = 2'h2;
  localparam logic [1:0] STB_ONE_CYC   = 2'h1;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,  // no master cycle
    M_ADDR = 2'b01,  // start cycle, address on bus
    M_DATA = 2'b10,  // waiting for acknowledge
    M_HOLD = 2'b11   // acknowledged, tail of cycle
  } bbc_mst_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,  // no slave cycle
    S_ID   = 2'b01,  // cycle after start, identity sampled
    S_SEL  = 2'b10,  // selected, waiting local ack
    S_ACK  = 2'b11   // acknowledge cycle on bus
  } bbc_slv_t;
endpackage

// ===== test/bbc_backplane_model.sv
`timescale 1ns/1ps
// backplane side: free-running bus clock, pulled-up start/ack/tm0
// lines and the slot decode that answers the identity match
module bbc_backplane_model #(
  parameter logic [3:0] CARD_SLOT = 4'hE,  // slot of the card under test
  parameter int         HALF_CLK  = 10     // core clocks per half period
) (
  input  wire logic i_clk,             // core clock paces the bus clock
  output logic      o_bus_clk,         // backplane clock, runs free
  output logic      o_start_n,         // start line, pull-up when idle
  output logic      o_ack_n,           // our ack drive, pull-up idle
  output logic      o_tm0_n,           // interim ack on tm0, pull-up
  output logic      o_card_id_match_n  // slot decode result, low on hit
);
  int         cnt;    // core clocks into this half period
  logic [3:0] bcast;  // slot broadcast in the last start cycle
  logic       sup;    // last start addressed the super-slot space

  initial begin
    cnt = 0;
    o_bus_clk = 1'h0;
    o_start_n = 1'h1;
    o_ack_n = 1'h1;
    o_tm0_n = 1'h1;
    bcast = 4'h0;
    sup = 1'h0;
  end

  // toggle off the core sampling edge so the sync stages never race it
  always @(negedge i_clk) begin
    cnt <= (cnt == HALF_CLK - 1) ? 0 : cnt + 1;
    if (cnt == HALF_CLK - 1) begin
      o_bus_clk <= ~o_bus_clk;
    end
  end

  // decode holds from the start cycle until the next one
  assign o_card_id_match_n = !((bcast == CARD_SLOT) || sup);

  // released lines read high through the pull-ups
  task automatic drive(input logic start_n, ack_n, tm0_n,
                       input logic [3:0] slot, input logic spr);
    o_start_n = start_n;
    o_ack_n = ack_n;
    o_tm0_n = tm0_n;
    if (!start_n) begin
      bcast = slot;
      sup = spr;
    end
  endtask
endmodule  // bbc_backplane_model

// ===== test/tb.sv
`timescale 1ns/1ps
// walks master and slave transfers against the backplane model
module tb;
  localparam int         LIMIT = 20000;  // core clocks before a cut
  localparam logic [3:0] CARD  = 4'hE;   // card slot, arbitrary value
  logic        i_clk = 1'h0;   // core clock
  logic        i_arst_n;       // async reset, low
  logic        grant_n;        // local slave grant
  logic        slave_interim_ack_n_n;        // block middle strobe request
  logic        local_ack_request_n_n;         // local ack request
  logic        hold_n;         // keep master read data
  logic        go_n;           // local master start
  logic        wr_i, blk_i;    // cycle kind for the sequencers
  logic [31:0] seed = 32'h45;  // xorshift state
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;     // run length guard
  wire logic   bclk, start_n, ack_drv_n, tm0_n, id_n, ack_wire_n;
  wire logic   drv_n, aen_n, den_n, stb, sel_n, ack_oe, ack_out;
  wire logic   addr_ld, slv_sel;

  // open-collector ack: either party pulls low, pull-up otherwise
  assign ack_wire_n = ack_drv_n & ~(ack_oe & ~ack_out);

  bbc_backplane_model #(.CARD_SLOT(CARD), .HALF_CLK(10)) u_bus (
    .i_clk(i_clk), .o_bus_clk(bclk), .o_start_n(start_n),
    .o_ack_n(ack_drv_n), .o_tm0_n(tm0_n), .o_card_id_match_n(id_n));

  bbc_buffer_ctrl u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus_clk(bclk),
    .i_start_n(start_n), .i_ack_n(ack_wire_n), .i_tm0_n(tm0_n),
    .i_slave_access_grant_n(grant_n), .i_slave_interim_ack_n(slave_interim_ack_n_n),
    .i_local_ack_request_n(local_ack_request_n_n), .i_master_data_hold_n(hold_n),
    .i_card_id_match_n(id_n), .i_master_go_n(go_n),
    .i_cycle_write(wr_i), .i_cycle_block(blk_i),
    .o_bus_drive_enable_n(drv_n), .o_local_addr_enable_n(aen_n),
    .o_local_data_enable_n(den_n), .o_local_data_load_strobe(stb),
    .o_addr_load_strobe(addr_ld), .o_addr_sel_n(sel_n),
    .o_ack_out(ack_out), .o_ack_oe(ack_oe), .o_slave_selected(slv_sel));

  // 200 MHz core clock
  always #2.5 i_clk = ~i_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected decode answer for a broadcast slot
  function automatic logic id_hit(input logic [3:0] slot, input logic sp);
    return (slot == CARD) || sp;
  endfunction

  function automatic logic [5:0] outs();
    return {drv_n, aen_n, den_n, stb, sel_n, ack_oe};
  endfunction

  task automatic chk(input string what, input logic [5:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs move one core clock after a bus edge, well ahead of the next
  task automatic rise();
    @(posedge bclk);
    @(negedge i_clk);
  endtask
  task automatic fall();
    @(negedge bclk);
    @(negedge i_clk);
  endtask
  task automatic look();
    repeat (6) @(negedge i_clk);
  endtask

  task automatic master_cycle(input logic wr, blk, hold, input int d);
    logic rd;
    rd = !wr;
    fall();
    wr_i = wr;
    blk_i = blk;
    go_n = 1'h0;
    hold_n = !hold;
    rise();
    go_n = 1'h1;
    look();
    chk("master start", outs(), 6'h18);
    fall();
    rise();
    u_bus.drive(1'h1, d != 0, !(blk && rd && d > 0), 4'h0, 1'h0);
    look();
    chk("master data phase", outs(), {rd, 5'h1A});
    for (int k = 0; k < d; k++) begin
      fall();
      look();
      chk("master wait", {drv_n, stb}, {rd, blk && rd});
      rise();
      u_bus.drive(1'h1, k + 1 != d, !(blk && rd && k + 1 < d), 4'h0, 1'h0);
    end
    fall();
    look();
    chk("master ack", outs(), {rd, 1'h1, !rd, rd, 2'h2});
    rise();
    u_bus.drive(1'h1, 1'h1, 1'h1, 4'h0, 1'h0);
    look();
    chk("master drive off", drv_n, 1'h1);
    fall();
    look();
    chk("master tail", {den_n, stb}, {!(rd && hold), 1'h0});
    rise();
    hold_n = 1'h1;
    fall();
    look();
    chk("master hold end", den_n, 1'h1);
  endtask

  task automatic slave_cycle(input logic wr, blk, early,
                             input logic [3:0] slot, input logic sp,
                             input int mids);
    logic hit;
    hit = id_hit(slot, sp);
    rise();
    wr_i = wr;
    blk_i = blk;
    grant_n = !early;
    u_bus.drive(1'h0, 1'h1, 1'h1, slot, sp);
    fall();
    rise();
    u_bus.drive(1'h1, 1'h1, 1'h1, slot, sp);
    fall();
    look();
    chk("slave select", {slv_sel, aen_n},
        {hit, !(hit && early)});
    if (!hit) begin
      grant_n = 1'h1;
      return;
    end
    if (!early) begin
      rise();
      grant_n = 1'h0;
      fall();
      look();
    end
    chk("slave grant", {aen_n, den_n, stb},
        {1'h0, !wr, wr});
    if (blk) begin
      fall();
      look();
      chk("block first hold", stb, 1'h1);
      fall();
      look();
      chk("block first drop", stb, 1'h0);
      repeat (mids) begin
        rise();
        slave_interim_ack_n_n = 1'h0;
        fall();
        look();
        chk("middle strobe", stb, 1'h1);
        fall();
        look();
        chk("middle strobe drop", stb, 1'h0);
        slave_interim_ack_n_n = 1'h1;
      end
    end
    rise();
    local_ack_request_n_n = 1'h0;
    fall();
    look();
    chk("final strobe", stb, wr);
    rise();
    local_ack_request_n_n = 1'h1;
    grant_n = 1'h1;
    look();
    chk("slave ack", {ack_oe, drv_n, ack_wire_n},
        {1'h1, wr, 1'h0});
    fall();
    look();
    chk("slave release", {aen_n, den_n, stb}, 3'h6);
    rise();
    look();
    chk("slave ack end", {ack_oe, drv_n}, 2'h1);
  endtask

  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard; a run that reaches it is counted as a mismatch
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      $display("test cut short after %0d cycles", cycles);
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    i_arst_n = 1'h0;
    {grant_n, slave_interim_ack_n_n, local_ack_request_n_n, hold_n, go_n} = 5'h1F;
    {wr_i, blk_i} = 2'h0;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'h1;
    repeat (10) @(negedge i_clk);
    chk("reset outputs", outs(), 6'h3A);
    chk("reset address load", addr_ld, 1'h0);
    rise();
    look();
    chk("idle outputs", outs(), 6'h3A);
    chk("idle address load", addr_ld, 1'h0);
    $display("test reset done");
    // slow read with hold, prompt write, block read with interim acks
    master_cycle(1'h0, 1'h0, 1'h1, 2);
    master_cycle(1'h1, 1'h0, 1'h0, 0);
    master_cycle(1'h0, 1'h1, 1'h0, 3);
    for (int k = 0; k < 10; k++) begin
      r = xs();
      master_cycle(r[0], r[1], r[2], int'(r[5:4]));
    end
    $display("test master done");
    slave_cycle(1'h1, 1'h0, 1'h1, CARD, 1'h0, 0);
    slave_cycle(1'h1, 1'h0, 1'h0, CARD, 1'h0, 0);
    slave_cycle(1'h0, 1'h0, 1'h1, 4'h2, 1'h1, 0);
    slave_cycle(1'h1, 1'h1, 1'h1, CARD, 1'h0, 2);
    slave_cycle(1'h1, 1'h1, 1'h0, CARD, 1'h0, 1);
    slave_cycle(1'h1, 1'h0, 1'h1, 4'h5, 1'h0, 0);
    for (int k = 0; k < 10; k++) begin
      r = xs();
      slave_cycle(r[0], r[0] & r[1], r[2], r[3] ? CARD : r[11:8],
                  r[12] & r[13], int'(r[5:4]));
    end
    $display("test slave done");
    end_of_test();
  end
endmodule  // tb
